// File: verilog/lcdrc_defines.vh
// Constants of the LCD row/column scan controller
`ifndef LCDRC_DEFINES_VH
`define LCDRC_DEFINES_VH

// ****************************************
// Clock and timing
// ****************************************
`define LCDRC_CORE_HZ 200000000
`define LCDRC_OSC_HZ 12288
`define LCDRC_OSC_DIV (`LCDRC_CORE_HZ / `LCDRC_OSC_HZ)
`define LCDRC_DIV_STD 6
`define LCDRC_DIV_R24 8
`define LCDRC_HALF_STD 3'd3
`define LCDRC_HALF_R24 3'd4
`define LCDRC_FRAME_STD 6'd32
`define LCDRC_FRAME_R24 6'd24

// ****************************************
// Command byte fields
// ****************************************
`define LCDRC_CONT_BIT 7
`define LCDRC_OP_BIT 6
`define LCDRC_OP2_BIT 5
`define LCDRC_OP3_BIT 4
`define LCDRC_TYPE_BIT 4
`define LCDRC_XADDR_MSB 5
`define LCDRC_BANK_CMD 2'b11

// ****************************************
// Mode encodings
// ****************************************
`define LCDRC_MUX_8 2'b01
`define LCDRC_MUX_16 2'b10
`define LCDRC_MUX_24 2'b11
`define LCDRC_MUX_32 2'b00
`define LCDRC_DISP_BLANK 2'b00
`define LCDRC_DISP_NORMAL 2'b01
`define LCDRC_DISP_ALLON 2'b10
`define LCDRC_DISP_INVERSE 2'b11
`define LCDRC_ORD_CHAR 2'b00
`define LCDRC_ORD_HALF 2'b01
`define LCDRC_ORD_FULL 2'b10

// ****************************************
// Memory and reset values
// ****************************************
`define LCDRC_COLS 40
`define LCDRC_LAST_COL 6'd39
`define LCDRC_MEM_WORDS 160
`define LCDRC_OWN_SUBADDR 4'h0
`define LCDRC_RST_MUX 2'b00
`define LCDRC_RST_DISP 2'b00
`define LCDRC_RST_MIXED 1'b0
`define LCDRC_RST_BANK 2'b00
`define LCDRC_RST_ORDER 2'b00

`endif

// File: verilog/lcdrc_tick_div.v
// Programmable tick divider
`timescale 1ns/1ps
module lcdrc_tick_div #(
  parameter W = 4
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire en_i,
  input wire [W-1:0] div_i,
  output reg tick_o
);

  reg [W-1:0] cnt_reg;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_reg <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (en_i) begin
        if (cnt_reg >= div_i - {{(W-1){1'b0}}, 1'b1}) begin
          cnt_reg <= {W{1'b0}};
          tick_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// File: verilog/lcdrc_top.v
// LCD row/column scan controller: timing, display memory, commands
`timescale 1ns/1ps
`include "lcdrc_defines.vh"
module lcdrc_top #(
  parameter OSC_DIV = `LCDRC_OSC_DIV
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire osc_resistor_pin_i,
  input wire ext_clk_i,
  input wire msg_start_i,
  input wire byte_valid_i,
  input wire [7:0] byte_data_i,
  input wire rd_req_i,
  output reg cas_clk_o,
  output reg cas_clk_oe_o,
  output reg sync_n_o,
  output reg [39:0] row_duty_o,
  output reg [39:0] drv_on_o,
  output reg [7:0] rd_data_o,
  output reg rd_valid_o,
  output reg wr_ack_o,
  output reg mixed_mode_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg osc_meta_reg;
  reg osc_pin_reg;
  reg ext_meta_reg;
  reg ext_sync_reg;
  reg ext_prev_reg;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      osc_meta_reg <= 1'b0;
      osc_pin_reg <= 1'b0;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else if (ce_i) begin
      osc_meta_reg <= osc_resistor_pin_i;
      osc_pin_reg <= osc_meta_reg;
      ext_meta_reg <= ext_clk_i;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  // ****************************************
  // Mode state
  // ****************************************
  reg [1:0] mux_reg;
  reg [1:0] disp_reg;
  reg mixed_reg;
  reg [1:0] top_bank_reg;
  reg [1:0] order_reg;
  reg [1:0] base_bank_reg;
  reg [1:0] bank_reg;
  reg [5:0] xaddr_reg;
  reg [3:0] subaddr_reg;
  reg cmd_phase_reg;
  reg [7:0] mem [0:`LCDRC_MEM_WORDS-1];

  // ****************************************
  // Oscillator prescaler and cascade clock
  // ****************************************
  wire ext_mode;
  wire osc_tick;
  wire half_tick;
  wire [2:0] half_div;
  wire clk_rise;
  wire [5:0] frame_len;

  assign ext_mode = osc_pin_reg;
  // Half clock period in oscillator ticks
  assign half_div = (mux_reg == `LCDRC_MUX_24) ?
    `LCDRC_HALF_R24 : `LCDRC_HALF_STD;
  assign frame_len = (mux_reg == `LCDRC_MUX_24) ?
    `LCDRC_FRAME_R24 : `LCDRC_FRAME_STD;

  lcdrc_tick_div #(.W(15)) u_osc_div (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(~ext_mode),
    .div_i(OSC_DIV[14:0]),
    .tick_o(osc_tick)
  );

  lcdrc_tick_div #(.W(3)) u_clk_div (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(osc_tick),
    .div_i(half_div),
    .tick_o(half_tick)
  );

  // Clock period tick from either source
  assign clk_rise = ext_mode ? (ext_sync_reg & ~ext_prev_reg) :
    (half_tick & ~cas_clk_o);

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cas_clk_o <= 1'b0;
      cas_clk_oe_o <= 1'b0;
    end else if (ce_i) begin
      cas_clk_oe_o <= ~ext_mode;
      if (ext_mode) begin
        cas_clk_o <= 1'b0;
      end else if (half_tick) begin
        cas_clk_o <= ~cas_clk_o;
      end
    end
  end

  // ****************************************
  // Frame counter and sync
  // ****************************************
  reg [5:0] frame_cnt_reg;
  reg [4:0] scan_row;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      frame_cnt_reg <= 6'd0;
      sync_n_o <= 1'b1;
    end else if (ce_i && clk_rise) begin
      if (frame_cnt_reg >= frame_len - 6'd1) begin
        frame_cnt_reg <= 6'd0;
        sync_n_o <= 1'b0;
      end else begin
        frame_cnt_reg <= frame_cnt_reg + 6'd1;
        sync_n_o <= 1'b1;
      end
    end
  end

  // Row index within the frame
  always @* begin
    case (mux_reg)
      `LCDRC_MUX_8: scan_row = {2'b00, frame_cnt_reg[2:0]};
      `LCDRC_MUX_16: scan_row = {1'b0, frame_cnt_reg[3:0]};
      default: scan_row = frame_cnt_reg[4:0];
    endcase
  end

  // ****************************************
  // Row and column output assignment
  // ****************************************
  reg [39:0] duty_next;
  reg [39:0] on_next;
  reg [4:0] out_row;
  reg [5:0] nrows;
  reg [1:0] row_bank;
  reg [7:0] col_byte;
  reg dot;
  integer i;

  always @* begin
    duty_next = 40'h0000000000;
    on_next = 40'h0000000000;
    out_row = 5'd0;
    col_byte = 8'h00;
    dot = 1'b0;
    case (mux_reg)
      `LCDRC_MUX_8: nrows = 6'd8;
      `LCDRC_MUX_16: nrows = 6'd16;
      `LCDRC_MUX_24: nrows = 6'd24;
      default: nrows = 6'd32;
    endcase
    row_bank = top_bank_reg + scan_row[4:3];
    for (i = 0; i < `LCDRC_COLS; i = i + 1) begin
      case (mux_reg)
        `LCDRC_MUX_8: out_row = {2'b00, i[2:0]};
        `LCDRC_MUX_16: out_row = {1'b0, i[3:0]};
        `LCDRC_MUX_24: out_row = (i >= 24) ? (i[4:0] - 5'd24) :
          i[4:0];
        default: out_row = i[4:0];
      endcase
      if (i < 8 || (i < 32 && (!mixed_reg || i < nrows))) begin
        duty_next[i] = 1'b1;
        on_next[i] = (out_row == scan_row);
      end else if (mixed_reg) begin
        col_byte = mem[row_bank * `LCDRC_COLS + i];
        dot = col_byte[scan_row[2:0]];
        case (disp_reg)
          `LCDRC_DISP_BLANK: on_next[i] = 1'b0;
          `LCDRC_DISP_NORMAL: on_next[i] = dot;
          `LCDRC_DISP_ALLON: on_next[i] = 1'b1;
          default: on_next[i] = ~dot;
        endcase
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      row_duty_o <= 40'h0000000000;
      drv_on_o <= 40'h0000000000;
      mixed_mode_o <= 1'b0;
    end else if (ce_i) begin
      row_duty_o <= duty_next;
      drv_on_o <= on_next;
      mixed_mode_o <= mixed_reg;
    end
  end

  // ****************************************
  // Data pointer advance
  // ****************************************
  reg [1:0] bank_next;
  reg [5:0] xaddr_next;
  reg [3:0] subaddr_next;
  reg col_step;
  wire [7:0] mem_idx;
  wire own_match;

  // Bank times forty, plus column
  assign mem_idx = {1'b0, bank_reg, 5'd0} + {3'b000, bank_reg, 3'd0} +
    {2'b00, xaddr_reg};
  assign own_match = mixed_reg &&
    (subaddr_reg == `LCDRC_OWN_SUBADDR);

  always @* begin
    bank_next = bank_reg;
    col_step = 1'b0;
    case (order_reg)
      `LCDRC_ORD_HALF: begin
        bank_next = {bank_reg[1], ~bank_reg[0]};
        col_step = bank_reg[0] != base_bank_reg[0];
      end
      `LCDRC_ORD_FULL: begin
        bank_next = bank_reg + 2'd1;
        col_step = (bank_reg + 2'd1) == base_bank_reg;
      end
      default: col_step = 1'b1;
    endcase
    xaddr_next = xaddr_reg;
    subaddr_next = subaddr_reg;
    if (col_step) begin
      if (xaddr_reg >= `LCDRC_LAST_COL) begin
        xaddr_next = 6'd0;
        subaddr_next = subaddr_reg + 4'd1;
      end else begin
        xaddr_next = xaddr_reg + 6'd1;
      end
    end
  end

  // ****************************************
  // Command decoder and memory access
  // ****************************************
  wire is_cmd;
  assign is_cmd = cmd_phase_reg;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mux_reg <= `LCDRC_RST_MUX;
      disp_reg <= `LCDRC_RST_DISP;
      mixed_reg <= `LCDRC_RST_MIXED;
      top_bank_reg <= `LCDRC_RST_BANK;
      order_reg <= `LCDRC_RST_ORDER;
      base_bank_reg <= 2'b00;
      bank_reg <= 2'b00;
      xaddr_reg <= 6'd0;
      subaddr_reg <= 4'h0;
      cmd_phase_reg <= 1'b0;
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      wr_ack_o <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= 1'b0;
      wr_ack_o <= 1'b0;
      if (msg_start_i) begin
        cmd_phase_reg <= 1'b1;
      end else if (byte_valid_i && is_cmd) begin
        cmd_phase_reg <= byte_data_i[`LCDRC_CONT_BIT];
        wr_ack_o <= 1'b1;
        if (!byte_data_i[`LCDRC_OP_BIT]) begin
          xaddr_reg <= byte_data_i[`LCDRC_XADDR_MSB:0];
        end else if (!byte_data_i[`LCDRC_OP2_BIT]) begin
          mixed_reg <= byte_data_i[`LCDRC_TYPE_BIT];
          disp_reg <= byte_data_i[3:2];
          mux_reg <= byte_data_i[1:0];
        end else if (!byte_data_i[`LCDRC_OP3_BIT]) begin
          subaddr_reg <= byte_data_i[3:0];
        end else if (byte_data_i[3:2] == `LCDRC_BANK_CMD) begin
          top_bank_reg <= byte_data_i[1:0];
        end else begin
          order_reg <= byte_data_i[3:2];
          base_bank_reg <= byte_data_i[1:0];
          bank_reg <= byte_data_i[1:0];
        end
      end else if (byte_valid_i) begin
        if (own_match) begin
          mem[mem_idx] <= byte_data_i;
          wr_ack_o <= 1'b1;
        end
        bank_reg <= bank_next;
        xaddr_reg <= xaddr_next;
        subaddr_reg <= subaddr_next;
      end else if (rd_req_i && mixed_reg) begin
        if (own_match) begin
          rd_data_o <= mem[mem_idx];
          rd_valid_o <= 1'b1;
        end
        bank_reg <= bank_next;
        xaddr_reg <= xaddr_next;
        subaddr_reg <= subaddr_next;
      end
    end
  end

endmodule

// File: dv/lcdrc_monitor.sv
// Port checker of the LCD scan controller
`timescale 1ns/1ps
module lcdrc_monitor (
  input wire core_clk_i,
  input wire rst_i,
  input wire osc_resistor_pin_i,
  input wire byte_valid_i,
  input wire rd_req_i,
  input wire cas_clk_o,
  input wire cas_clk_oe_o,
  input wire sync_n_o,
  input wire [39:0] row_duty_o,
  input wire [39:0] drv_on_o,
  input wire rd_valid_o,
  input wire wr_ack_o,
  input wire mixed_mode_o
);
  // ********
  // Assertions
  // ********
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_sync_low;
    (!sync_n_o) [*8];
  endsequence
  sequence s_cas_high;
    cas_clk_o [*8];
  endsequence
  a_ext_oe: assert property ($rose(osc_resistor_pin_i) |->
    ##[1:4] !cas_clk_oe_o) else $error("clock output still driven");
  a_sync_width: assert property ($fell(sync_n_o) |-> s_sync_low)
    else $error("frame sync pulse too short");
  a_cas_half: assert property (cas_clk_oe_o && !osc_resistor_pin_i &&
    $rose(cas_clk_o) |-> s_cas_high) else $error("clock half too short");
  a_fixed_outs: assert property (|row_duty_o |->
    row_duty_o[7:0] == 8'hff && row_duty_o[39:32] == 8'h00)
    else $error("fixed outputs misassigned");
  a_duty_group: assert property (row_duty_o[15:8] == {8{row_duty_o[8]}} &&
    row_duty_o[23:16] == {8{row_duty_o[16]}} &&
    row_duty_o[31:24] == {8{row_duty_o[24]}}) else $error("group split");
  a_ack_cause: assert property (wr_ack_o |-> $past(byte_valid_i))
    else $error("ack without byte");
  a_read_cause: assert property (rd_valid_o |->
    $past(rd_req_i) && mixed_mode_o) else $error("read without request");
  a_one_row: assert property (mixed_mode_o && $past(mixed_mode_o, 2) &&
    row_duty_o == 40'h00ffffffff && $past(row_duty_o, 2) == row_duty_o
    |-> $onehot0(drv_on_o[31:0])) else $error("several rows selected");
endmodule
bind lcdrc_top lcdrc_monitor i_mon (.core_clk_i, .rst_i, .osc_resistor_pin_i,
  .byte_valid_i, .rd_req_i, .cas_clk_o, .cas_clk_oe_o, .sync_n_o,
  .row_duty_o, .drv_on_o, .rd_valid_o, .wr_ack_o, .mixed_mode_o);

// File: dv/lcdrc_host.sv
// Host model sending commands, data and reads
`timescale 1ns/1ps
module lcdrc_host (
  input wire clk_i,
  input wire wr_ack_i,
  input wire rd_valid_i,
  input wire [7:0] rd_data_i,
  output logic msg_start_o,
  output logic byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic rd_req_o
);
  initial begin
    msg_start_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_data_o = 8'h00;
    rd_req_o = 1'b0;
  end
  task automatic msg();
    @(negedge clk_i) msg_start_o <= 1'b1;
    @(negedge clk_i) msg_start_o <= 1'b0;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    @(negedge clk_i) byte_valid_o <= 1'b1;
    byte_data_o <= b;
    @(negedge clk_i) byte_valid_o <= 1'b0;
    byte_data_o <= ~b;
    ack = wr_ack_i;
    @(negedge clk_i) ack = ack | wr_ack_i;
  endtask
  task automatic get(output logic v, output logic [7:0] d);
    @(negedge clk_i) rd_req_o <= 1'b1;
    @(negedge clk_i) rd_req_o <= 1'b0;
    v = rd_valid_i;
    @(negedge clk_i) v = v | rd_valid_i;
    d = rd_data_i;
  endtask
  // First location: subaddress, column, then order and bank
  task automatic loc(input [3:0] sub, input [5:0] col, input [1:0] o, b);
    logic a;
    msg();
    put({4'he, sub}, a);
    put({2'h2, col}, a);
    put({4'h7, o, b}, a);
  endtask
endmodule

// File: dv/testbench.sv
// Testbench of the LCD row/column scan controller
`timescale 1ns/1ps
module testbench;
  localparam integer D = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic osc = 1'b0;
  logic ext = 1'b0;
  logic ext_run = 1'b0;
  logic ms, bv, rq, cc, coe, sync_n, rv, wa, mm, a;
  logic [7:0] bd, rd, d;
  logic [39:0] rdut, drv;
  integer miscompares = 0;
  integer total_checks = 0;
  integer n, k;
  always #2.5 core_clk = ~core_clk;
  always #25 if (ext_run) ext = ~ext;
  lcdrc_top #(.OSC_DIV(D)) i_dut (.core_clk_i(core_clk), .rst_i(rst),
    .ce_i(1'b1), .osc_resistor_pin_i(osc), .ext_clk_i(ext),
    .msg_start_i(ms), .byte_valid_i(bv), .byte_data_i(bd),
    .rd_req_i(rq), .cas_clk_o(cc), .cas_clk_oe_o(coe), .sync_n_o(sync_n),
    .row_duty_o(rdut), .drv_on_o(drv), .rd_data_o(rd), .rd_valid_o(rv),
    .wr_ack_o(wa), .mixed_mode_o(mm));
  lcdrc_host i_host (.clk_i(core_clk), .wr_ack_i(wa), .rd_valid_i(rv),
    .rd_data_i(rd), .msg_start_o(ms), .byte_valid_o(bv),
    .byte_data_o(bd), .rd_req_o(rq));
  // ********
  // Helpers
  // ********
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [39:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic e);
    i_host.put(b, a);
    chk("data ack", a, e);
  endtask
  task automatic rd_chk(input logic v, input logic [7:0] e);
    i_host.get(a, d);
    chk("read valid", a, v);
    if (v)
      chk("read data", d, e);
  endtask
  task automatic mode(input logic [7:0] c);
    i_host.msg();
    i_host.put(c, a);
    chk("cmd ack", a, 1);
    repeat (4) @(negedge core_clk);
  endtask
  task automatic gap(input logic s, output integer n);
    logic p;
    integer i;
    for (i = 0; i < 2; i++) begin
      p = 1'b1;
      n = 0;
      while (!((s ? !sync_n : cc) && !p)) begin
        p = s ? !sync_n : cc;
        @(negedge core_clk);
        n++;
        if (n > 2000) begin
          miscompares++;
          stop_test();
        end
      end
    end
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    repeat (6) @(negedge core_clk);
    chk("mixed", mm, 0);
    chk("row duty", rdut, 40'h00ffffffff);
    chk("clk oe", coe, 1);
    $display("test reset done");
  endtask
  task automatic t_modes();
    for (k = 1; k <= 4; k++) begin
      mode({6'h15, k[1:0]});
      chk("row duty", rdut, (40'h1 << (8 * k)) - 40'h1);
      chk("mixed", mm, 1);
    end
    gap(1'b0, n);
    chk("clk period", n, 6 * D);
    gap(1'b1, n);
    chk("frame", n, 192 * D);
    mode(8'h57);
    gap(1'b0, n);
    chk("clk period", n, 8 * D);
    gap(1'b1, n);
    chk("frame", n, 192 * D);
    mode(8'h54);
    $display("test modes done");
  endtask
  task automatic t_ram();
    i_host.loc(4'h0, 6'd10, 2'b01, 2'b00);
    wr(8'h3c, 1'b1);
    wr(8'ha5, 1'b1);
    wr(8'h5a, 1'b1);
    i_host.loc(4'h0, 6'd20, 2'b10, 2'b10);
    wr(8'h69, 1'b1);
    wr(8'h96, 1'b1);
    i_host.loc(4'h0, 6'd10, 2'b00, 2'b00);
    rd_chk(1'b1, 8'h3c);
    rd_chk(1'b1, 8'h5a);
    i_host.loc(4'h0, 6'd10, 2'b00, 2'b01);
    rd_chk(1'b1, 8'ha5);
    i_host.loc(4'h0, 6'd20, 2'b00, 2'b11);
    rd_chk(1'b1, 8'h96);
    i_host.loc(4'h0, 6'd39, 2'b00, 2'b00);
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b0);
    i_host.loc(4'h1, 6'd5, 2'b00, 2'b00);
    rd_chk(1'b0, 8'h00);
    i_host.loc(4'hf, 6'd39, 2'b00, 2'b00);
    wr(8'h44, 1'b0);
    wr(8'h55, 1'b1);
    i_host.loc(4'h0, 6'd0, 2'b00, 2'b00);
    rd_chk(1'b1, 8'h55);
    $display("test ram done");
  endtask
  task automatic t_row();
    mode(8'h46);
    chk("mixed", mm, 0);
    chk("row duty", rdut, 40'h00ffffffff);
    i_host.loc(4'h0, 6'd0, 2'b00, 2'b00);
    wr(8'h77, 1'b0);
    rd_chk(1'b0, 8'h00);
    for (k = 0; k < 20; k++) begin
      repeat (37) @(negedge core_clk);
      chk("split rows", drv[15:0], drv[31:16]);
      chk("one row", $countones(drv[15:0]), 1);
    end
    mode(8'h45);
    for (k = 0; k < 20; k++) begin
      repeat (37) @(negedge core_clk);
      chk("quad rows", drv[23:0], drv[31:8]);
      chk("one row", $countones(drv[7:0]), 1);
    end
    mode(8'h54);
    i_host.loc(4'h0, 6'd0, 2'b00, 2'b00);
    rd_chk(1'b1, 8'h55);
    $display("test row mode done");
  endtask
  task automatic t_disp();
    logic [31:0] v;
    logic [1:0] b;
    logic x;
    integer j, r;
    v = 32'h5ac33c96;
    for (j = 0; j < 4; j++) begin
      i_host.loc(4'h0, 6'd32, 2'b00, j[1:0]);
      wr(v[8 * j +: 8], 1'b1);
    end
    for (k = 0; k < 4; k++) begin
      mode({4'h5, k[1:0], 2'b00});
      mode({6'h1f, k[1:0]});
      for (j = 0; j < 16; j++) begin
        repeat (37) @(negedge core_clk);
        r = 0;
        for (n = 0; n < 32; n++)
          if (drv[n])
            r = n;
        chk("row select", drv[31:0], 32'h1 << r);
        b = k[1:0] + r[4:3];
        x = v[8 * b + r[2:0]];
        if (k == 0)
          x = 1'b0;
        else if (k == 2)
          x = 1'b1;
        else if (k == 3)
          x = ~x;
        chk("column dot", drv[32], x);
      end
    end
    $display("test display done");
  endtask
  task automatic t_ext();
    gap(1'b0, n);
    chk("clk period", n, 6 * D);
    repeat (13) @(negedge core_clk);
    osc = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("clk oe", coe, 0);
    ext_run = 1'b1;
    gap(1'b1, n);
    chk("ext frame", n, 320);
    $display("test external clock done");
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_modes();
    t_ram();
    t_row();
    t_disp();
    t_ext();
    stop_test();
  end
endmodule
